// [rtl/jbs_port.sv]
// Boundary-scan test port with reusable test pads and per-pad output options
`timescale 1ns/1ps
module jbs_port
   import jbs_pkg::*;
#(
   parameter int              BSR_LEN    = BSR_LEN_D0,
   // Identity values below are arbitrary
   parameter logic [3:0]      ID_VERSION = 4'h3,
   parameter logic [15:0]     ID_PART    = 16'hA5C3,
   parameter logic [10:0]     ID_MFR     = 11'h2B5
) (
   input  wire logic                 core_clk,
   input  wire logic                 rst_n,
   input  wire logic [REG_AW-1:0]    reg_addr,
   input  wire logic [31:0]          reg_wdata,
   input  wire logic                 reg_wr,
   input  wire logic                 reg_rd,
   output logic      [31:0]          reg_rdata,
   input  wire logic [NUM_PADS-1:0]  pad_i,
   output logic      [NUM_PADS-1:0]  pad_o,
   output logic      [NUM_PADS-1:0]  pad_oe,
   output logic      [NUM_PADS-1:0]  slew_fast,
   input  wire logic [NUM_PADS-1:0]  user_out,
   input  wire logic [NUM_PADS-1:0]  user_oe,
   output logic      [NUM_PADS-1:0]  user_in,
   input  wire logic [BSR_LEN-1:0]   bsr_capture,
   output logic      [BSR_LEN-1:0]   bsr_update
);

   localparam int DR_MAX = (BSR_LEN > ID_LEN) ? BSR_LEN : ID_LEN;
   localparam int LEN_W  = $clog2(DR_MAX + 1);

   // ======================================================================
   // Software registers
   logic                  scan_en;
   logic [NUM_PADS-1:0]   cfg_od;
   logic [NUM_PADS-1:0]   cfg_slew;
   logic [NUM_PADS-1:0]   cfg_gnd;
   logic [UCODE_LEN-1:0]  usercode;
   logic [SIG_LEN-1:0]    user_sig;
   jbs_tap_e              tap_state;
   jbs_tap_e              next_tap_state;
   logic [IR_LEN-1:0]     ir;
   logic [IR_LEN-1:0]     ir_sh;

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         scan_en  <= 1'b1;
         cfg_od   <= PAD_CFG_RST;
         cfg_slew <= PAD_CFG_RST;
         cfg_gnd  <= PAD_CFG_RST;
         usercode <= UCODE_RST;
         user_sig <= SIG_RST;
      end else if (reg_wr) begin
         unique case (reg_addr)
            REG_CTRL:  scan_en  <= reg_wdata[CTRL_SCAN_EN];
            REG_OD:    cfg_od   <= reg_wdata[NUM_PADS-1:0];
            REG_SLEW:  cfg_slew <= reg_wdata[NUM_PADS-1:0];
            REG_GND:   cfg_gnd  <= reg_wdata[NUM_PADS-1:0];
            REG_UCODE: usercode <= reg_wdata[UCODE_LEN-1:0];
            REG_SIG:   user_sig <= reg_wdata[SIG_LEN-1:0];
            default: ;
         endcase
      end
   end

   // Unmapped reads return zero
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         reg_rdata <= 32'h0000_0000;
      end else if (reg_rd) begin
         unique case (reg_addr)
            REG_CTRL:   reg_rdata <= 32'(scan_en);
            REG_OD:     reg_rdata <= 32'(cfg_od);
            REG_SLEW:   reg_rdata <= 32'(cfg_slew);
            REG_GND:    reg_rdata <= 32'(cfg_gnd);
            REG_UCODE:  reg_rdata <= usercode;
            REG_SIG:    reg_rdata <= 32'(user_sig);
            REG_STATUS: reg_rdata <= 32'({ir, tap_state});
            default:    reg_rdata <= 32'h0000_0000;
         endcase
      end else begin
         reg_rdata <= 32'h0000_0000;
      end
   end

   // Slew bit passes through one more register to the pad buffer; reset leaves every pad slow
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         slew_fast <= PAD_CFG_RST;
      end else begin
         slew_fast <= cfg_slew;
      end
   end

   // ======================================================================
   // Pad synchronisers and test clock edges
   logic [NUM_PADS-1:0] pad_s1;
   logic [NUM_PADS-1:0] pad_s2;
   logic                tck_d;
   logic                tck_rise;
   logic                tck_fall;
   logic                tms_s;
   logic                tdi_s;

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         pad_s1 <= PAD_CFG_RST;
         pad_s2 <= PAD_CFG_RST;
         tck_d  <= 1'b0;
      end else begin
         pad_s1 <= pad_i;
         pad_s2 <= pad_s1;
         tck_d  <= pad_s2[PAD_TCK];
      end
   end

   assign tck_rise = pad_s2[PAD_TCK] & ~tck_d;
   assign tck_fall = ~pad_s2[PAD_TCK] & tck_d;
   assign tms_s    = pad_s2[PAD_TMS];
   assign tdi_s    = pad_s2[PAD_TDI];

   // ======================================================================
   // TAP controller; held in reset while the pads serve user logic
   always_comb begin
      unique case (tap_state)
         TAP_RESET:  next_tap_state = tms_s ? TAP_RESET  : TAP_IDLE;
         TAP_IDLE:   next_tap_state = tms_s ? TAP_SEL_DR : TAP_IDLE;
         TAP_SEL_DR: next_tap_state = tms_s ? TAP_SEL_IR : TAP_CAP_DR;
         TAP_CAP_DR: next_tap_state = tms_s ? TAP_EX1_DR : TAP_SH_DR;
         TAP_SH_DR:  next_tap_state = tms_s ? TAP_EX1_DR : TAP_SH_DR;
         TAP_EX1_DR: next_tap_state = tms_s ? TAP_UPD_DR : TAP_PAU_DR;
         TAP_PAU_DR: next_tap_state = tms_s ? TAP_EX2_DR : TAP_PAU_DR;
         TAP_EX2_DR: next_tap_state = tms_s ? TAP_UPD_DR : TAP_SH_DR;
         TAP_UPD_DR: next_tap_state = tms_s ? TAP_SEL_DR : TAP_IDLE;
         TAP_SEL_IR: next_tap_state = tms_s ? TAP_RESET  : TAP_CAP_IR;
         TAP_CAP_IR: next_tap_state = tms_s ? TAP_EX1_IR : TAP_SH_IR;
         TAP_SH_IR:  next_tap_state = tms_s ? TAP_EX1_IR : TAP_SH_IR;
         TAP_EX1_IR: next_tap_state = tms_s ? TAP_UPD_IR : TAP_PAU_IR;
         TAP_PAU_IR: next_tap_state = tms_s ? TAP_EX2_IR : TAP_PAU_IR;
         TAP_EX2_IR: next_tap_state = tms_s ? TAP_UPD_IR : TAP_SH_IR;
         TAP_UPD_IR: next_tap_state = tms_s ? TAP_SEL_DR : TAP_IDLE;
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n || !scan_en) begin
         tap_state <= TAP_RESET;
      end else if (tck_rise) begin
         tap_state <= next_tap_state;
      end
   end

   // ======================================================================
   // Instruction register
   always_ff @(posedge core_clk) begin
      if (!rst_n || !scan_en) begin
         ir    <= OP_IDCODE;
         ir_sh <= IR_CAPTURE;
      end else if (tck_rise) begin
         unique case (tap_state)
            TAP_RESET:  ir    <= OP_IDCODE;
            TAP_CAP_IR: ir_sh <= IR_CAPTURE;
            TAP_SH_IR:  ir_sh <= {tdi_s, ir_sh[IR_LEN-1:1]};
            TAP_UPD_IR: ir    <= ir_sh;
            default: ;
         endcase
      end
   end

   // ======================================================================
   // Data registers share one shifter; the selected length sets where TDI enters
   logic [LEN_W-1:0]  dr_len;
   logic [DR_MAX-1:0] dr_sh;
   logic [DR_MAX-1:0] next_dr_sh;
   logic [DR_MAX-1:0] cap_val;
   logic [ID_LEN-1:0] id_word;
   logic              bsr_sel;

   assign id_word = {ID_VERSION, ID_PART, ID_MFR, ID_LSB_ONE};
   assign bsr_sel = (ir == OP_SAMPLE) || (ir == OP_EXTEST);

   always_comb begin
      unique case (ir)
         OP_IDCODE: begin
            dr_len  = LEN_W'(ID_LEN);
            cap_val = DR_MAX'(id_word);
         end
         OP_USERCODE: begin
            dr_len  = LEN_W'(UCODE_LEN);
            cap_val = DR_MAX'(usercode);
         end
         OP_SIG: begin
            dr_len  = LEN_W'(SIG_LEN);
            cap_val = DR_MAX'(user_sig);
         end
         OP_SAMPLE, OP_EXTEST: begin
            dr_len  = LEN_W'(BSR_LEN);
            cap_val = DR_MAX'(bsr_capture);
         end
         default: begin
            dr_len  = LEN_W'(1);
            cap_val = '0;
         end
      endcase
   end

   for (genvar i = 0; i < DR_MAX; i++) begin : g_dr_bit
      if (i == DR_MAX - 1) begin : g_top
         assign next_dr_sh[i] = (dr_len == LEN_W'(i + 1)) ? tdi_s : 1'b0;
      end else begin : g_mid
         assign next_dr_sh[i] = (dr_len == LEN_W'(i + 1)) ? tdi_s :
                                (dr_len >  LEN_W'(i + 1)) ? dr_sh[i+1] : 1'b0;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n || !scan_en) begin
         dr_sh <= '0;
      end else if (tck_rise) begin
         if (tap_state == TAP_CAP_DR) begin
            dr_sh <= cap_val;
         end else if (tap_state == TAP_SH_DR) begin
            dr_sh <= next_dr_sh;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         bsr_update <= '0;
      end else if (tck_rise && tap_state == TAP_UPD_DR && bsr_sel) begin
         bsr_update <= dr_sh[BSR_LEN-1:0];
      end
   end

   // ======================================================================
   // Pads: test port while scan is enabled, user pins otherwise
   logic shifting;
   logic tdo_bit;

   assign shifting = (tap_state == TAP_SH_DR) || (tap_state == TAP_SH_IR);
   assign tdo_bit  = (tap_state == TAP_SH_IR) ? ir_sh[0] : dr_sh[0];

   for (genvar k = 0; k < NUM_PADS; k++) begin : g_pad
      always_ff @(posedge core_clk) begin
         if (!rst_n) begin
            pad_o[k]  <= 1'b0;
            pad_oe[k] <= 1'b0;
         end else if (scan_en && k != PAD_TDO) begin
            pad_o[k]  <= 1'b0;
            pad_oe[k] <= 1'b0;
         end else if (scan_en) begin
            // TDO moves on the falling test clock so the tester samples it settled
            if (tck_fall || tap_state == TAP_RESET) begin
               pad_o[k]  <= tdo_bit;
               pad_oe[k] <= shifting;
            end
         end else if (cfg_gnd[k]) begin
            // Grounding ignores user_out, so the pad's logic stays free
            pad_o[k]  <= 1'b0;
            pad_oe[k] <= 1'b1;
         end else if (cfg_od[k]) begin
            pad_o[k]  <= 1'b0;
            pad_oe[k] <= user_oe[k] & ~user_out[k];
         end else begin
            pad_o[k]  <= user_out[k];
            pad_oe[k] <= user_oe[k];
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         user_in <= PAD_CFG_RST;
      end else begin
         user_in <= scan_en ? PAD_CFG_RST : pad_s2;
      end
   end

   // ======================================================================
   // Checks
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);

   sequence s_ir_update;
      tck_rise && scan_en && tap_state == TAP_UPD_IR;
   endsequence
   sequence s_id_capture;
      tck_rise && scan_en && tap_state == TAP_CAP_DR && ir == OP_IDCODE;
   endsequence

   chk_ir_width_load: assert property (s_ir_update |=> ir == $past(ir_sh))
      else $error("instruction not loaded from shifter");
   chk_sig_full_width: assert property (
      (ir == OP_SIG) |-> dr_len == LEN_W'(16))
      else $error("signature register length wrong");
   chk_ucode_capture: assert property (
      (tck_rise && scan_en && tap_state == TAP_CAP_DR && ir == OP_USERCODE)
      |=> dr_sh[31:0] == $past(usercode) && dr_len == LEN_W'(32))
      else $error("user code not captured whole");
   chk_bsr_chain_len: assert property (bsr_sel |-> dr_len == LEN_W'(BSR_LEN))
      else $error("boundary chain length wrong");
   chk_id_field_layout: assert property (
      s_id_capture |=> dr_sh[31:28] == ID_VERSION && dr_sh[27:12] == ID_PART
                       && dr_sh[11:1] == ID_MFR)
      else $error("identification fields misplaced");
   chk_id_lsb_one: assert property (s_id_capture |=> dr_sh[0] == 1'b1)
      else $error("identification lsb not one");
   chk_pins_released: assert property (
      (!scan_en && !cfg_gnd[PAD_TMS] && !cfg_od[PAD_TMS])
      |=> pad_oe[PAD_TMS] == $past(user_oe[PAD_TMS])
          && pad_o[PAD_TMS] == $past(user_out[PAD_TMS]))
      else $error("test pad not released to user");
   chk_od_never_high: assert property (
      $past(!scan_en) |-> (pad_o & pad_oe & $past(cfg_od & ~cfg_gnd)) == 4'h0)
      else $error("open-drain pad drove high");
   chk_slew_follow: assert property (
      (reg_wr && reg_addr == REG_SLEW) |=> ##1 slew_fast == $past(reg_wdata[3:0], 2))
      else $error("slew setting not applied");
   chk_gnd_drive: assert property (
      (!scan_en && cfg_gnd[PAD_TDI]) |=> pad_oe[PAD_TDI] && !pad_o[PAD_TDI])
      else $error("grounded pad not driven low");

endmodule

// [rtl/jbs_pkg.sv]
// Constants, register map and TAP state encoding of the boundary-scan port
package jbs_pkg;

   // =====================================================================
   // Scan register widths
   localparam int IR_LEN    = 10;
   localparam int SIG_LEN   = 16;
   localparam int UCODE_LEN = 32;
   localparam int ID_LEN    = 32;

   // Boundary-scan chain lengths, one per device density
   localparam int BSR_LEN_D0 = 96;
   localparam int BSR_LEN_D1 = 192;
   localparam int BSR_LEN_D2 = 288;
   localparam int BSR_LEN_D3 = 480;
   localparam int BSR_LEN_D4 = 624;

   // =====================================================================
   // Identification word layout, MSB first
   localparam int ID_VER_W   = 4;
   localparam int ID_PART_W  = 16;
   localparam int ID_MFR_W   = 11;
   localparam logic ID_LSB_ONE = 1'b1;

   // =====================================================================
   // Instruction opcodes
   localparam logic [IR_LEN-1:0] OP_EXTEST   = 10'h000;
   localparam logic [IR_LEN-1:0] OP_SAMPLE   = 10'h055;
   localparam logic [IR_LEN-1:0] OP_IDCODE   = 10'h059;
   localparam logic [IR_LEN-1:0] OP_USERCODE = 10'h007;
   localparam logic [IR_LEN-1:0] OP_SIG      = 10'h079;
   localparam logic [IR_LEN-1:0] OP_BYPASS   = 10'h3FF;
   localparam logic [IR_LEN-1:0] IR_CAPTURE  = 10'h001;

   // =====================================================================
   // Test-port pads, reusable as user pins
   localparam int NUM_PADS = 4;
   localparam int PAD_TCK  = 0;
   localparam int PAD_TMS  = 1;
   localparam int PAD_TDI  = 2;
   localparam int PAD_TDO  = 3;

   // =====================================================================
   // Register map (byte addresses) and reset values
   localparam int REG_AW = 8;
   localparam logic [REG_AW-1:0] REG_CTRL   = 8'h00;
   localparam logic [REG_AW-1:0] REG_OD     = 8'h04;
   localparam logic [REG_AW-1:0] REG_SLEW   = 8'h08;
   localparam logic [REG_AW-1:0] REG_GND    = 8'h0C;
   localparam logic [REG_AW-1:0] REG_UCODE  = 8'h10;
   localparam logic [REG_AW-1:0] REG_SIG    = 8'h14;
   localparam logic [REG_AW-1:0] REG_STATUS = 8'h18;
   localparam int CTRL_SCAN_EN = 0;
   localparam logic [NUM_PADS-1:0] PAD_CFG_RST = 4'h0;
   localparam logic [UCODE_LEN-1:0] UCODE_RST = 32'h0000_0000;
   localparam logic [SIG_LEN-1:0]   SIG_RST   = 16'h0000;

   // =====================================================================
   // TAP controller, Gray steps from select to exit2 on both scan paths
   typedef enum logic [3:0] {
      TAP_RESET   = 4'h0,
      TAP_IDLE    = 4'h1,
      TAP_SEL_DR  = 4'h3,
      TAP_CAP_DR  = 4'h2,
      TAP_SH_DR   = 4'h6,
      TAP_EX1_DR  = 4'h7,
      TAP_PAU_DR  = 4'h5,
      TAP_EX2_DR  = 4'h4,
      TAP_UPD_DR  = 4'hC,
      TAP_SEL_IR  = 4'hD,
      TAP_CAP_IR  = 4'hF,
      TAP_SH_IR   = 4'hE,
      TAP_EX1_IR  = 4'hA,
      TAP_PAU_IR  = 4'hB,
      TAP_EX2_IR  = 4'h9,
      TAP_UPD_IR  = 4'h8
   } jbs_tap_e;

endpackage

// [sim/jbs_tester.sv]
// Behavioural boundary-scan test controller driving the test pads
`timescale 1ns/1ps
module jbs_tester (
   output logic      tck,
   output logic      tms,
   output logic      tdi,
   input  wire logic tdo
);
   initial begin
      tck = 1'b0;
      tms = 1'b1;
      tdi = 1'b0;
   end
   // =====================================================================
   // One 320 ns TCK period; edges kept off the core clock grid
   task automatic tap_bit(input logic m, input logic d, output logic q);
      #7;
      tms = m;
      tdi = d;
      #156;
      q = tdo;
      tck = 1'b1;
      #157;
      tck = 1'b0;
   endtask
   task automatic tap_reset();
      logic q;
      // Callers return on a core edge; the offset keeps every TCK edge off it
      #5;
      repeat (5) tap_bit(1'b1, 1'b0, q);
      tap_bit(1'b0, 1'b0, q);
   endtask
   // From idle: scan n bits LSB first, back to idle; TCK stands low after
   task automatic scan(input logic ir, input int n, input logic [127:0] din,
                       output logic [127:0] dout);
      logic q;
      dout = '0;
      #5;
      tap_bit(1'b1, 1'b0, q);
      if (ir) tap_bit(1'b1, 1'b0, q);
      tap_bit(1'b0, 1'b0, q);
      tap_bit(1'b0, 1'b0, q);
      for (int i = 0; i < n; i++) begin
         tap_bit(i == n - 1, din[i], q);
         dout[i] = q;
      end
      tap_bit(1'b1, 1'b0, q);
      tap_bit(1'b0, 1'b0, q);
      tdi = ~din[n-1];
   endtask
endmodule

// [sim/jbs_port_tb.sv]
// Self-checking testbench of the boundary-scan port
`timescale 1ns/1ps
module jbs_port_tb;
   import jbs_pkg::*;
   localparam int         BSR   = BSR_LEN_D0;
   localparam int         LIMIT = 20000;
   // Identity values are arbitrary
   localparam logic [3:0]  VER  = 4'h6;
   localparam logic [15:0] PART = 16'h1E2D;
   localparam logic [10:0] MFR  = 11'h0F3;
   localparam logic [31:0] ID_EXP = {VER, PART, MFR, 1'b1};

   logic core_clk = 1'b0;
   logic rst_n = 1'b0;
   logic [7:0] reg_addr = '0;
   logic [31:0] reg_wdata = '0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [31:0] reg_rdata;
   logic [3:0] pad_i, pad_o, pad_oe, slew_fast, user_in, pad_drv = '0;
   logic [3:0] user_out = '0;
   logic [3:0] user_oe = '0;
   logic [BSR-1:0] bsr_capture, bsr_update;
   logic user_mode = 1'b0;
   logic tck, tms, tdi, tdo_wire;
   logic rd_pend = 1'b0;
   logic [31:0] exp_q[$];
   int error_cnt = 0;
   int checks_done = 0;
   int cyc_cnt = 0;

   always #20 core_clk = ~core_clk;
   // TDO pad has a pull-up while the port is not driving it
   assign tdo_wire = (pad_oe[PAD_TDO] === 1'b1) ? pad_o[PAD_TDO] : 1'b1;
   assign pad_i = user_mode ? pad_drv : {tdo_wire, tdi, tms, tck};

   jbs_port #(.BSR_LEN(BSR), .ID_VERSION(VER), .ID_PART(PART), .ID_MFR(MFR)) DUT (
      .core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pad_i(pad_i),
      .pad_o(pad_o), .pad_oe(pad_oe), .slew_fast(slew_fast), .user_out(user_out),
      .user_oe(user_oe), .user_in(user_in), .bsr_capture(bsr_capture),
      .bsr_update(bsr_update));
   jbs_tester u_tst (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo_wire));

   // =====================================================================
   // Checking and closing
   task automatic chk(input string nm, input logic [127:0] seen, input logic [127:0] ex);
      checks_done++;
      if (seen !== ex) begin
         error_cnt++;
         $display("wrong value %s expected %0h seen %0h", nm, ex, seen);
      end
   endtask
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   always @(posedge core_clk) begin
      if (rd_pend) chk("reg_rdata", 128'(reg_rdata), 128'(exp_q.pop_front()));
      rd_pend <= reg_rd;
      cyc_cnt <= cyc_cnt + 1;
      if (cyc_cnt == LIMIT) begin
         error_cnt++;
         tally_and_finish();
      end
   end

   // =====================================================================
   // Register bus
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      @(posedge core_clk);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      exp_q.push_back(e);
      @(posedge core_clk);
      reg_rd <= 1'b0;
   endtask

   // =====================================================================
   // Main sequence
   initial begin
      logic [127:0] din, dout;
      logic [31:0]  ucode;
      logic [15:0]  sig;
      logic [3:0]   od, gnd, sl, eo, eoe;
      logic [9:0]   codes[5];
      int           lens[5];
      logic [127:0] expv[5];
      void'($urandom(30456));
      bsr_capture <= {$urandom, $urandom, $urandom};
      repeat (20) @(posedge core_clk);
      rst_n <= 1'b1;
      rd(REG_STATUS, {18'h0, OP_IDCODE, TAP_RESET});
      rd(REG_CTRL, 32'h1);
      for (int i = 0; i < 3; i++) rd(REG_OD + 8'(4 * i), 32'h0);
      rd(8'h1C, 32'h0);
      wr(REG_STATUS, 32'hFFFF_FFFF);
      rd(REG_STATUS, {18'h0, OP_IDCODE, TAP_RESET});
      ucode = $urandom;
      sig = 16'($urandom);
      wr(REG_UCODE, ucode);
      wr(REG_SIG, {16'h0, sig});
      rd(REG_UCODE, ucode);
      rd(REG_SIG, {16'h0, sig});
      #1;
      chk("slew_reset", 128'(slew_fast), 128'(0));
      chk("user_in_scan", 128'(user_in), 128'(0));
      u_tst.tap_reset();
      din = {$urandom, $urandom, $urandom, $urandom};
      u_tst.scan(1'b0, 40, din, dout);
      chk("idcode", dout, {88'h0, din[7:0], ID_EXP});
      chk("id_first_bit", 128'(dout[0]), 128'(1));
      // Unknown codes fall back to a one-bit bypass that captures zero
      codes = '{OP_USERCODE, OP_SIG, OP_BYPASS, OP_EXTEST, OP_SAMPLE};
      lens = '{UCODE_LEN, SIG_LEN, 1, BSR, BSR};
      expv = '{128'(ucode), 128'(sig), 128'h0, 128'(bsr_capture), 128'(bsr_capture)};
      for (int k = 0; k < 5; k++) begin
         din = {$urandom, $urandom, $urandom, $urandom};
         din[17:8] = codes[k];
         u_tst.scan(1'b1, 18, din, dout);
         chk("ir_capture", dout, {110'h0, din[7:0], IR_CAPTURE});
         rd(REG_STATUS, {18'h0, codes[k], TAP_IDLE});
         din = {$urandom, $urandom, $urandom, $urandom};
         u_tst.scan(1'b0, lens[k] + 8, din, dout);
         chk("dr_shift", dout, expv[k] | (128'(din[7:0]) << lens[k]));
         if (lens[k] == BSR) chk("bsr_update", 128'(bsr_update), 128'(din[BSR+7:8]));
      end
      // Pads handed to user logic; the pad model switches at the same time
      wr(REG_CTRL, 32'h0);
      user_mode <= 1'b1;
      for (int k = 0; k < 8; k++) begin
         od  = 4'($urandom);
         gnd = 4'($urandom);
         sl  = 4'($urandom);
         wr(REG_OD, {28'h0, od});
         wr(REG_GND, {28'h0, gnd});
         wr(REG_SLEW, {28'h0, sl});
         rd(REG_SLEW, {28'h0, sl});
         @(posedge core_clk);
         user_out <= 4'($urandom);
         user_oe  <= 4'($urandom);
         pad_drv  <= 4'($urandom);
         repeat (4) @(posedge core_clk);
         #1;
         eo  = ~od & ~gnd & user_out;
         eoe = gnd | (user_oe & ~(od & user_out));
         chk("pad_o", 128'(pad_o), 128'(eo));
         chk("pad_oe", 128'(pad_oe), 128'(eoe));
         chk("slew_fast", 128'(slew_fast), 128'(sl));
         chk("user_in", 128'(user_in), 128'(pad_drv));
      end
      repeat (3) @(posedge core_clk);
      tally_and_finish();
   end
endmodule
